// >>> sim/nvs_sram_model.sv
`timescale 1ns/100ps
module nvs_sram_model (
  input wire logic reset_out,
  input wire logic reset_oe_n,
  input wire logic battery_low_out,
  input wire logic battery_low_oe_n,
  output logic reset_line_n,
  output logic battery_low_line_n
);
  // ----------------
  // board pull-ups
  // ----------------
  // released lines float, so the pull-up sets the high level
  assign reset_line_n = reset_oe_n ? 1'b1 : reset_out;
  assign battery_low_line_n = battery_low_oe_n ? 1'b1 : battery_low_out;
endmodule

// >>> sim/nvs_supervisor_checker.sv
`timescale 1ns/100ps
`include "nvs_map.svh"
module nvs_supervisor_checker
  import nvs_pkg::*;
#(
  parameter int TICK_CYCLES = 2,
  parameter int WPT_TICKS = 4,
  parameter int REC_TICKS = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic [`NVS_SEL_W-1:0] sel,
  input wire logic trip_level_sel,
  input wire logic below_trip_hi,
  input wire logic below_trip_lo,
  input wire logic below_switchover,
  input wire logic [`NVS_CS_W-1:0] gated_cs_n,
  input wire logic reset_out,
  input wire logic reset_oe_n,
  input wire logic battery_low_out,
  input wire logic battery_low_oe_n,
  input wire logic battery_to_backed_supply,
  input wire logic [1:0] gating_state,
  input wire logic trip_level_used
);
  // ----------------
  // helper counters
  // ----------------
  // slack covers synchronizer delay and tick phase
  localparam int DRAIN_MAX = (WPT_TICKS + 1) * TICK_CYCLES;
  localparam int HOLD_MIN = (REC_TICKS - 1) * TICK_CYCLES;
  logic trip;
  int drain_cnt;
  int low_cnt;
  assign trip = trip_level_sel ? below_trip_hi : below_trip_lo;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_cnt <= 0;
      low_cnt <= 0;
    end else begin
      drain_cnt <= (gating_state == NVS_DRAIN) ? drain_cnt + 1 : 0;
      low_cnt <= (trip || reset_oe_n) ? 0 : low_cnt + 1;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_access;
    (!cs_n && $stable(sel) && !trip && gating_state == NVS_NORMAL)[*4];
  endsequence
  sequence s_idle;
    (cs_n && gating_state == NVS_NORMAL)[*4];
  endsequence
  AST_DECODE: assert property (s_access |-> gated_cs_n == ~(4'h1 << sel))
    else $error("gated enable decode wrong");
  AST_IDLE: assert property (s_idle |-> gated_cs_n == `NVS_CS_IDLE)
    else $error("gated enables not idle");
  AST_BLOCKED: assert property (gating_state[1] |-> gated_cs_n == `NVS_CS_IDLE)
    else $error("enable passed while blocked");
  AST_CUTOFF: assert property (gating_state == NVS_DRAIN |-> drain_cnt <= DRAIN_MAX)
    else $error("access not cut off");
  AST_TRIP_SEL: assert property ($stable(trip_level_sel)[*5] |-> trip_level_used == trip_level_sel)
    else $error("trip select not taken");
  AST_FAIL_RESET: assert property ($rose(trip) |-> ##[1:6] !reset_oe_n)
    else $error("reset late after fail");
  AST_RESET_HOLD: assert property ($rose(reset_oe_n) |-> low_cnt >= HOLD_MIN)
    else $error("reset released early");
  AST_OPEN_DRAIN: assert property (reset_out == 1'b0 && battery_low_out == 1'b0)
    else $error("open drain data high");
  AST_SWITCH: assert property ($stable(below_switchover)[*5] |-> battery_to_backed_supply == below_switchover)
    else $error("backed supply source wrong");
  AST_BACKUP_QUIET: assert property (below_switchover[*5] |-> $stable(battery_low_oe_n))
    else $error("battery status moved in backup");
endmodule

bind nvs_supervisor nvs_supervisor_checker #(
  .TICK_CYCLES(TICK_CYCLES),
  .WPT_TICKS(WPT_TICKS),
  .REC_TICKS(REC_TICKS)
) nvs_supervisor_checker_inst (
  .clk(clk),
  .rst_n(rst_n),
  .cs_n(cs_n),
  .sel(sel),
  .trip_level_sel(trip_level_sel),
  .below_trip_hi(below_trip_hi),
  .below_trip_lo(below_trip_lo),
  .below_switchover(below_switchover),
  .gated_cs_n(gated_cs_n),
  .reset_out(reset_out),
  .reset_oe_n(reset_oe_n),
  .battery_low_out(battery_low_out),
  .battery_low_oe_n(battery_low_oe_n),
  .battery_to_backed_supply(battery_to_backed_supply),
  .gating_state(gating_state),
  .trip_level_used(trip_level_used)
);

// >>> sim/tb.sv
`timescale 1ns/100ps
`include "nvs_map.svh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb;
  import nvs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic [1:0] sel = 2'h0;
  logic trip_level_sel = 1'b0;
  logic below_trip_hi = 1'b0;
  logic below_trip_lo = 1'b0;
  logic below_switchover = 1'b0;
  logic battery_weak = 1'b1;
  logic [3:0] gated_cs_n;
  logic [1:0] gating_state;
  logic reset_out, reset_oe_n, battery_low_out, battery_low_oe_n, battery_to_backed_supply, trip_level_used;
  logic reset_line_n, battery_low_line_n;
  int bad_count = 0;
  int check_count = 0;
  // {cs_n, sel, expected gated enables}
  logic [6:0] rows [6] = '{7'h4F, 7'h0E, 7'h1D, 7'h2B, 7'h37, 7'h7F};
  always #5 clk = ~clk;
  // short counts keep the run brief
  nvs_supervisor #(.TICK_CYCLES(2), .WPT_TICKS(4), .CER_TICKS(8), .REC_TICKS(10), .CHECK_TICKS(64'd20))
    nvs_supervisor_inst (
    .clk(clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sel(sel),
    .trip_level_sel(trip_level_sel),
    .below_trip_hi(below_trip_hi),
    .below_trip_lo(below_trip_lo),
    .below_switchover(below_switchover),
    .battery_weak(battery_weak),
    .gated_cs_n(gated_cs_n),
    .reset_out(reset_out),
    .reset_oe_n(reset_oe_n),
    .battery_low_out(battery_low_out),
    .battery_low_oe_n(battery_low_oe_n),
    .battery_to_backed_supply(battery_to_backed_supply),
    .gating_state(gating_state),
    .trip_level_used(trip_level_used)
  );
  nvs_sram_model nvs_sram_model_inst (
    .reset_out(reset_out),
    .reset_oe_n(reset_oe_n),
    .battery_low_out(battery_low_out),
    .battery_low_oe_n(battery_low_oe_n),
    .reset_line_n(reset_line_n),
    .battery_low_line_n(battery_low_line_n)
  );
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // tests need about 400 cycles; the margin covers added scenarios
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    end_of_test;
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    w(2);
    `CHK("rst gated", 4'hF, gated_cs_n)
    `CHK("rst line", 1'b0, reset_line_n)
    w(8);
    rst_n = 1'b1;
    w(60);
    `CHK("rec line", 1'b1, reset_line_n)
    `CHK("weak at power-up", 1'b0, battery_low_line_n)
    battery_weak = 1'b0;
    w(10);
    `CHK("low held", 1'b0, battery_low_line_n)
    w(50);
    `CHK("periodic check", 1'b1, battery_low_line_n)
    foreach (rows[i]) begin
      {cs_n, sel} = rows[i][6:4];
      w(5);
      `CHK("decode", rows[i][3:0], gated_cs_n)
    end
    cs_n = 1'b0;
    sel = 2'h2;
    w(5);
    below_trip_lo = 1'b1;
    w(5);
    `CHK("drain state", NVS_DRAIN, gating_state)
    `CHK("drain keeps", 4'hB, gated_cs_n)
    `CHK("fail line", 1'b0, reset_line_n)
    w(16);
    `CHK("cut off", 4'hF, gated_cs_n)
    cs_n = 1'b1;
    w(4);
    `CHK("protect", NVS_PROTECT, gating_state)
    below_trip_lo = 1'b0;
    cs_n = 1'b0;
    w(6);
    `CHK("recover", NVS_RECOVER, gating_state)
    `CHK("recover gated", 4'hF, gated_cs_n)
    w(40);
    `CHK("normal again", 4'hB, gated_cs_n)
    `CHK("rec again", 1'b1, reset_line_n)
    cs_n = 1'b1;
    battery_weak = 1'b1;
    below_trip_lo = 1'b1;
    below_switchover = 1'b1;
    w(60);
    `CHK("on battery", 1'b1, battery_to_backed_supply)
    `CHK("no backup check", 1'b1, battery_low_line_n)
    below_switchover = 1'b0;
    below_trip_lo = 1'b0;
    w(8);
    `CHK("on supply", 1'b0, battery_to_backed_supply)
    `CHK("power-up check", 1'b0, battery_low_line_n)
    rst_n = 1'b0;
    trip_level_sel = 1'b1;
    w(10);
    rst_n = 1'b1;
    w(60);
    `CHK("trip sel", 1'b1, trip_level_used)
    below_trip_lo = 1'b1;
    w(6);
    `CHK("low trip ignored", NVS_NORMAL, gating_state)
    below_trip_hi = 1'b1;
    w(6);
    `CHK("high trip", NVS_PROTECT, gating_state)
    end_of_test;
  end
endmodule

// >>> src/nvs_map.svh
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH

// timebase: one tick per microsecond at 100 MHz
`define NVS_CLK_MHZ 100
`define NVS_TICK_CYCLES (`NVS_CLK_MHZ)
// times in microseconds
`define NVS_WPT_US 150
`define NVS_CER_US 120000
`define NVS_REC_US 200000
// check interval in hours, and ticks per hour
`define NVS_CHECK_HOURS 24
`define NVS_US_PER_HOUR 3600000000
// one tick per microsecond, so each time in ticks equals its microsecond value
`define NVS_WPT_TICKS (`NVS_WPT_US)
`define NVS_CER_TICKS (`NVS_CER_US)
`define NVS_REC_TICKS (`NVS_REC_US)
`define NVS_CHECK_TICKS (64'd`NVS_US_PER_HOUR * `NVS_CHECK_HOURS)
// select decode: one-hot, active low
`define NVS_SEL_W 2
`define NVS_CS_W 4
`define NVS_CS_IDLE 4'hF

`endif

// >>> src/nvs_pkg.sv
package nvs_pkg;
  typedef enum logic [1:0] {
    NVS_NORMAL = 2'b00,
    NVS_DRAIN = 2'b01,
    NVS_PROTECT = 2'b10,
    NVS_RECOVER = 2'b11
  } nvs_state_type;

  typedef enum logic [1:0] {
    NVS_RST_HOLD = 2'b00,
    NVS_RST_TIMING = 2'b01,
    NVS_RST_RELEASED = 2'b10
  } nvs_rst_state_type;
endpackage

// >>> src/nvs_supervisor.sv
`timescale 1ns/100ps
// Functional notes
// - with supply valid and enable low, exactly one gated enable goes low
// - normally gated enables follow enable; enable high drives all four high
// - power fail forces all gated enables high, write-protecting memories
// - an access already running at power fail may finish first
// - access unfinished at write-protect timeout is cut off unconditionally
// - trip level chosen by static threshold-select input
// - after supply returns, enables held high for enable recovery time
// - reset output driven low within write-protect timeout of power fail
// - reset held low for reset recovery time once supply valid
// - reset output is open drain
// - battery checked at power-up and every 24 hours while powered
// - failing check asserts active-low battery-low output
// - battery-low stays until a later check passes
// - no battery check or status change during battery backup
// - battery-low output is open drain
// - backed supply switches to battery below switchover level
`include "nvs_map.svh"
module nvs_supervisor
  import nvs_pkg::*;
#(
  parameter int TICK_CYCLES = `NVS_TICK_CYCLES,
  parameter int WPT_TICKS = `NVS_WPT_TICKS,
  parameter int CER_TICKS = `NVS_CER_TICKS,
  parameter int REC_TICKS = `NVS_REC_TICKS,
  parameter longint CHECK_TICKS = `NVS_CHECK_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic [`NVS_SEL_W-1:0] sel,
  input wire logic trip_level_sel,
  input wire logic below_trip_hi,
  input wire logic below_trip_lo,
  input wire logic below_switchover,
  input wire logic battery_weak,
  output logic [`NVS_CS_W-1:0] gated_cs_n,
  output logic reset_out,
  output logic reset_oe_n,
  output logic battery_low_out,
  output logic battery_low_oe_n,
  output logic battery_to_backed_supply,
  output nvs_pkg::nvs_state_type gating_state,
  output logic trip_level_used
);
  import nvs_pkg::*;

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic [6:0] raw_in;
  logic [6:0] syn_in;
  // bit order matters: the slices below pick the fields back out
  assign raw_in = {
    cs_n,
    sel,
    trip_level_sel,
    below_trip_hi,
    below_trip_lo,
    below_switchover
  };

  // safe value: enable high, supply failing, battery connected
  nvs_sync #(.WIDTH(7)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .reset_value(7'h4F),
    .sync_out(syn_in)
  );

  logic cs_n_s;
  logic [1:0] sel_s;
  logic ths_s;
  logic fail_s;
  logic so_s;
  assign cs_n_s = syn_in[6];
  assign sel_s = syn_in[5:4];
  assign ths_s = syn_in[3];
  assign so_s = syn_in[0];
  // select high takes the upper comparator, low the lower one
  assign fail_s = ths_s ? syn_in[2] : syn_in[1];

  // battery comparator on its own synchroniser; no check runs before
  // the main inputs are primed, so its safe value is never used
  logic weak_s;
  nvs_sync #(.WIDTH(1)) u_weak_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(battery_weak),
    .reset_value(1'b0),
    .sync_out(weak_s)
  );

  // --------------------------------------------------------------
  // timebase
  // --------------------------------------------------------------
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_cnt_next;
  logic tick;
  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] count_down(input logic [31:0] v, input logic t);
    count_down = (t && v != 32'h0) ? v - 32'h1 : v;
  endfunction

  function automatic logic [3:0] decode_cs(input logic en_n, input logic [1:0] s);
    decode_cs = `NVS_CS_IDLE;
    if (!en_n) begin
      decode_cs[s] = 1'b0;
    end
  endfunction

  // --------------------------------------------------------------
  // enable gating machine
  // --------------------------------------------------------------
  nvs_state_type state_reg;
  nvs_state_type state_next;
  logic [31:0] gate_cnt_reg;
  logic [31:0] gate_cnt_next;
  logic [3:0] cs_reg;
  logic [3:0] cs_next;

  always_comb begin
    state_next = state_reg;
    gate_cnt_next = count_down(gate_cnt_reg, tick);
    tick_cnt_next = tick ? 16'h0 : tick_cnt_reg + 16'h1;
    cs_next = `NVS_CS_IDLE;
    case (state_reg)
      NVS_NORMAL: begin
        if (fail_s) begin
          gate_cnt_next = 32'(WPT_TICKS);
          state_next = cs_reg != `NVS_CS_IDLE ? NVS_DRAIN : NVS_PROTECT;
          cs_next = cs_n_s ? `NVS_CS_IDLE : cs_reg;
        end else begin
          cs_next = decode_cs(cs_n_s, sel_s);
        end
      end
      NVS_DRAIN: begin
        // hold the running access steady; only its end or timeout stops it
        if (cs_n_s || gate_cnt_reg == 32'h0) begin
          state_next = NVS_PROTECT;
        end else begin
          cs_next = cs_reg;
        end
      end
      NVS_PROTECT: begin
        if (!fail_s) begin
          gate_cnt_next = 32'(CER_TICKS);
          state_next = NVS_RECOVER;
        end
      end
      NVS_RECOVER: begin
        if (fail_s) begin
          state_next = NVS_PROTECT;
        end else if (gate_cnt_reg == 32'h0) begin
          state_next = NVS_NORMAL;
        end
      end
      default: begin
        state_next = NVS_PROTECT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= NVS_PROTECT;
      gate_cnt_reg <= 32'h0;
      cs_reg <= `NVS_CS_IDLE;
      tick_cnt_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      gate_cnt_reg <= gate_cnt_next;
      cs_reg <= cs_next;
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // --------------------------------------------------------------
  // power-on reset
  // --------------------------------------------------------------
  nvs_rst_state_type rs_reg;
  nvs_rst_state_type rs_next;
  logic [31:0] rec_cnt_reg;
  logic [31:0] rec_cnt_next;
  logic rst_oe_n_reg;
  logic rst_oe_n_next;

  always_comb begin
    rs_next = rs_reg;
    rec_cnt_next = count_down(rec_cnt_reg, tick);
    case (rs_reg)
      NVS_RST_HOLD: begin
        if (!fail_s) begin
          rec_cnt_next = 32'(REC_TICKS);
          rs_next = NVS_RST_TIMING;
        end
      end
      NVS_RST_TIMING: begin
        if (fail_s) begin
          rs_next = NVS_RST_HOLD;
        end else if (rec_cnt_reg == 32'h0) begin
          rs_next = NVS_RST_RELEASED;
        end
      end
      NVS_RST_RELEASED: begin
        if (fail_s) begin
          rs_next = NVS_RST_HOLD;
        end
      end
      default: begin
        rs_next = NVS_RST_HOLD;
      end
    endcase
    // pulls low unless released; one edge after fail is seen, far within the timeout
    rst_oe_n_next = rs_next == NVS_RST_RELEASED;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_reg <= NVS_RST_HOLD;
      rec_cnt_reg <= 32'h0;
      rst_oe_n_reg <= 1'b0;
    end else begin
      rs_reg <= rs_next;
      rec_cnt_reg <= rec_cnt_next;
      rst_oe_n_reg <= rst_oe_n_next;
    end
  end

  // --------------------------------------------------------------
  // battery monitor
  // --------------------------------------------------------------
  logic [63:0] chk_cnt_reg;
  logic [63:0] chk_cnt_next;
  logic powered_reg;
  logic powered_next;
  logic bl_oe_n_reg;
  logic bl_oe_n_next;
  logic so_reg;
  logic so_next;
  logic check;

  always_comb begin
    powered_next = !so_s && !fail_s;
    so_next = so_s;
    check = 1'b0;
    chk_cnt_next = chk_cnt_reg;
    bl_oe_n_next = bl_oe_n_reg;
    if (!so_s && !fail_s) begin
      if (!powered_reg || chk_cnt_reg == 64'h0) begin
        check = 1'b1;
        // a full interval of ticks, so periodic checks are never closer than it
        chk_cnt_next = 64'(CHECK_TICKS);
      end else if (tick) begin
        chk_cnt_next = chk_cnt_reg - 64'h1;
      end
    end
    if (check) begin
      bl_oe_n_next = !weak_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_cnt_reg <= 64'h0;
      powered_reg <= 1'b0;
      bl_oe_n_reg <= 1'b1;
      so_reg <= 1'b1;
    end else begin
      chk_cnt_reg <= chk_cnt_next;
      powered_reg <= powered_next;
      bl_oe_n_reg <= bl_oe_n_next;
      so_reg <= so_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  logic ths_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ths_reg <= 1'b0;
    end else begin
      ths_reg <= ths_s;
    end
  end

  assign gated_cs_n = cs_reg;
  assign reset_out = 1'b0;
  assign reset_oe_n = rst_oe_n_reg;
  assign battery_low_out = 1'b0;
  assign battery_low_oe_n = bl_oe_n_reg;
  assign battery_to_backed_supply = so_reg;
  assign gating_state = state_reg;
  assign trip_level_used = ths_reg;
endmodule

// >>> src/nvs_sync.sv
`timescale 1ns/100ps
module nvs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_value,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;
  logic primed_reg;
  logic primed2_reg;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // reset value is a constant at the ports where it is used
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      primed_reg <= 1'b0;
      primed2_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      primed_reg <= 1'b1;
      primed2_reg <= primed_reg;
    end
  end

  // until two edges have passed, present the safe value
  assign sync_out = primed2_reg ? sync_reg : reset_value;
endmodule
